// file: core/smhp_core.sv
// smhp_core: spi command port, strap pins, clock output and interrupt of the modem
// assumes the serial, reset and strap pins are asynchronous to clk_sys and sclk stays well below clk_sys/4
`default_nettype none

module smhp_core #(
	parameter int EVT_W = smhp_pkg::EVT_W,
	parameter int CLKOUT_HALF = smhp_pkg::CLKOUT_HALF
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic device_reset_n,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	output logic spi_sdo_o,
	output logic spi_sdo_oe,
	input wire logic [smhp_pkg::CMD_W-1:0] tx_word,
	output logic [smhp_pkg::CMD_W-1:0] cmd_word,
	output logic cmd_valid,
	input wire logic crystal_osc_enable_n,
	input wire logic clock_scheme_sel0,
	input wire logic clock_scheme_sel1,
	input wire logic reference_enable,
	input wire logic bandpass_filter_enable,
	output smhp_pkg::smhp_clk_src_t clock_src,
	output logic crystal_osc_on,
	output logic reference_on,
	output logic filter_on,
	output logic clock_out_pin,
	output logic power_down,
	input wire logic [EVT_W-1:0] event_in,
	output logic [EVT_W-1:0] irq_pending,
	output logic irq_pin
);
	localparam int DIV_W = $clog2(CLKOUT_HALF + 1);
	localparam int CW = smhp_pkg::CMD_W;

	typedef struct packed {
		logic cs_m;
		logic cs_s;
		logic sck_m;
		logic sck_s;
		logic sck_d;
		logic sdi_m;
		logic sdi_s;
		logic rst_m;
		logic rst_s;
		logic [smhp_pkg::PIN_W-1:0] pin_m;
		logic [smhp_pkg::PIN_W-1:0] pin_s;
		smhp_pkg::smhp_spi_st_t st;
		logic [CW-1:0] sh_in;
		logic [CW-1:0] sh_out;
		logic [smhp_pkg::CNT_W-1:0] cnt;
		logic sdo;
		logic sdo_oe;
		logic [CW-1:0] cmd;
		logic cmd_valid;
		logic [smhp_pkg::CTRL_W-1:0] ctrl;
		logic [EVT_W-1:0] mask;
		logic irq_clr;
		logic [EVT_W-1:0] clr_bits;
		logic [DIV_W-1:0] div;
		logic clk_out;
		smhp_pkg::smhp_clk_src_t src;
		logic xtal_on;
		logic ref_on;
		logic bpf_on;
		logic pd;
	} smhp_core_state_t;

	smhp_core_state_t r_reg, r_next;
	logic fall;
	logic clkout_en;
	logic irq_rst;

	// ------------------------------------------------------------
	// reset of everything except the synchronisers and the clock source
	// ------------------------------------------------------------
	// synchronisers keep running in power-down so the pin release is seen
	function automatic smhp_core_state_t clear_func(input smhp_core_state_t s);
		smhp_core_state_t t;
		t = s;
		t.st = smhp_pkg::SMHP_ST_IDLE;
		t.sh_in = '0;
		t.sh_out = '0;
		t.cnt = '0;
		t.sdo = 1'b0;
		t.sdo_oe = 1'b0;
		t.cmd = '0;
		t.cmd_valid = 1'b0;
		t.ctrl = smhp_pkg::CTRL_RST;
		t.mask = smhp_pkg::MASK_RST;
		t.irq_clr = 1'b0;
		t.clr_bits = '0;
		t.div = '0;
		t.clk_out = 1'b0;
		t.xtal_on = 1'b0;
		t.ref_on = 1'b0;
		t.bpf_on = 1'b0;
		t.pd = 1'b1;
		return t;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// two stages on every pin; sck_d is a third stage for edge finding
	always_comb begin
		r_next = r_reg;
		r_next.cs_m = spi_cs_n;
		r_next.cs_s = r_reg.cs_m;
		r_next.sck_m = spi_sclk;
		r_next.sck_s = r_reg.sck_m;
		r_next.sck_d = r_reg.sck_s;
		r_next.sdi_m = spi_sdi;
		r_next.sdi_s = r_reg.sdi_m;
		r_next.rst_m = device_reset_n;
		r_next.rst_s = r_reg.rst_m;
		r_next.pin_m = {bandpass_filter_enable, reference_enable, clock_scheme_sel1,
			clock_scheme_sel0, crystal_osc_enable_n};
		r_next.pin_s = r_reg.pin_m;
		r_next.cmd_valid = 1'b0;
		r_next.irq_clr = 1'b0;
		r_next.pd = 1'b0;
		fall = r_reg.sck_d & ~r_reg.sck_s;

		// serial transfer: first bit goes out at chip-select fall, later ones after each falling edge
		case (r_reg.st)
			smhp_pkg::SMHP_ST_IDLE: begin
				r_next.cnt = '0;
				if (!r_reg.cs_s) begin
					r_next.st = smhp_pkg::SMHP_ST_XFER;
					r_next.sh_out = tx_word;
					r_next.sdo = tx_word[CW-1];
					r_next.sdo_oe = 1'b1;
				end
			end
			smhp_pkg::SMHP_ST_XFER: begin
				if (r_reg.cs_s) begin
					r_next.st = smhp_pkg::SMHP_ST_IDLE;
					r_next.sdo_oe = 1'b0;
					r_next.cnt = '0;
					// a short or long frame is dropped rather than half applied
					if (r_reg.cnt == smhp_pkg::CMD_BITS) begin
						r_next.cmd = r_reg.sh_in;
						r_next.cmd_valid = 1'b1;
						case (smhp_pkg::cmd_addr(r_reg.sh_in))
							smhp_pkg::ADDR_CTRL: begin
								r_next.ctrl = r_reg.sh_in[smhp_pkg::CTRL_W-1:0];
							end
							smhp_pkg::ADDR_MASK: begin
								r_next.mask = r_reg.sh_in[EVT_W-1:0];
							end
							smhp_pkg::ADDR_IRQ_CLR: begin
								r_next.irq_clr = 1'b1;
								r_next.clr_bits = r_reg.sh_in[EVT_W-1:0];
							end
							default: begin
								r_next.irq_clr = 1'b0;
							end
						endcase
					end
				end else if (fall) begin
					r_next.sh_in = {r_reg.sh_in[CW-2:0], r_reg.sdi_s};
					if (r_reg.cnt != smhp_pkg::CNT_MAX) begin
						r_next.cnt = r_reg.cnt + 1'b1;
					end
					r_next.sh_out = {r_reg.sh_out[CW-2:0], 1'b0};
					r_next.sdo = r_reg.sh_out[CW-2];
				end
			end
			default: begin
				r_next.st = smhp_pkg::SMHP_ST_IDLE;
			end
		endcase

		// analog enables follow the straps; all of them drop in power-down
		r_next.xtal_on = ~r_reg.pin_s[smhp_pkg::P_XTAL_N];
		r_next.ref_on = r_reg.pin_s[smhp_pkg::P_REF];
		r_next.bpf_on = r_reg.pin_s[smhp_pkg::P_BPF];

		// sel1 picks the input side, sel0 lets the clock leave on the output pin
		if (!r_reg.pin_s[smhp_pkg::P_XTAL_N]) begin
			r_next.src = smhp_pkg::SMHP_SRC_XTAL;
		end else if (r_reg.pin_s[smhp_pkg::P_SEL1]) begin
			r_next.src = smhp_pkg::SMHP_SRC_CMOS;
		end else begin
			r_next.src = smhp_pkg::SMHP_SRC_INT;
		end
		clkout_en = r_reg.ctrl[smhp_pkg::CTRL_CLKOUT] & r_reg.pin_s[smhp_pkg::P_SEL0] &
			(r_reg.src != smhp_pkg::SMHP_SRC_CMOS);

		// divider enable pulse toggles the clock output; an external cmos clock is never echoed
		if (!clkout_en) begin
			r_next.div = '0;
			r_next.clk_out = 1'b0;
		end else if (r_reg.div == DIV_W'(CLKOUT_HALF - 1)) begin
			r_next.div = '0;
			r_next.clk_out = ~r_reg.clk_out;
		end else begin
			r_next.div = r_reg.div + 1'b1;
		end

		if (sys_rst) begin
			r_next = clear_func('0);
			r_next.cs_m = 1'b1;
			r_next.cs_s = 1'b1;
			r_next.src = smhp_pkg::SMHP_SRC_INT;
		end else if (!r_reg.rst_s) begin
			r_next = clear_func(r_next);
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		r_reg <= r_next;
	end

	// ------------------------------------------------------------
	// interrupt shaping
	// ------------------------------------------------------------
	// the pin reset also clears pending events
	assign irq_rst = sys_rst | ~r_reg.rst_s;

	smhp_irq_gen #(
		.EVT_W(EVT_W),
		.PULSE_CYC(smhp_pkg::IRQ_PULSE_CYC)
	) u_irq (
		.clk_sys(clk_sys),
		.sys_rst(irq_rst),
		.event_in(event_in),
		.mask(r_reg.mask),
		.level_mode(r_reg.ctrl[smhp_pkg::CTRL_IRQ_LEVEL]),
		.active_high(r_reg.ctrl[smhp_pkg::CTRL_IRQ_POS]),
		.clear_pulse(r_reg.irq_clr),
		.clear_bits(r_reg.clr_bits),
		.irq_pin(irq_pin),
		.pending(irq_pending)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign spi_sdo_o = r_reg.sdo;
	assign spi_sdo_oe = r_reg.sdo_oe;
	assign cmd_word = r_reg.cmd;
	assign cmd_valid = r_reg.cmd_valid;
	assign clock_src = r_reg.src;
	assign crystal_osc_on = r_reg.xtal_on;
	assign reference_on = r_reg.ref_on;
	assign filter_on = r_reg.bpf_on;
	assign clock_out_pin = r_reg.clk_out;
	assign power_down = r_reg.pd;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_shift_capture: assert property ((r_reg.st == smhp_pkg::SMHP_ST_XFER && !r_reg.cs_s && r_reg.rst_s &&
		r_reg.sck_d && !r_reg.sck_s) |=> r_reg.sh_in[0] == $past(r_reg.sdi_s))
		else $error("sampled bit not shifted in");
	a_cnt_step: assert property ((r_reg.st == smhp_pkg::SMHP_ST_XFER && !r_reg.cs_s && r_reg.rst_s &&
		r_reg.sck_d && !r_reg.sck_s && r_reg.cnt == '0) |=> r_reg.cnt == 5'h01)
		else $error("bit count did not advance");
	a_cnt_clear: assert property ((r_reg.cs_s && r_reg.st == smhp_pkg::SMHP_ST_XFER) |=> r_reg.cnt == '0)
		else $error("bit count not cleared");
	a_sdo_hiz: assert property (r_reg.cs_s |=> !spi_sdo_oe)
		else $error("output driven while deselected");
	a_sdi_ignored: assert property ((r_reg.cs_s && r_reg.rst_s && r_reg.st == smhp_pkg::SMHP_ST_IDLE)
		|=> $stable(r_reg.sh_in))
		else $error("input taken while deselected");
	a_sdo_first: assert property ((r_reg.st == smhp_pkg::SMHP_ST_IDLE && !r_reg.cs_s && r_reg.rst_s)
		|=> spi_sdo_oe && spi_sdo_o == $past(tx_word[CW-1]))
		else $error("first output bit wrong");
	a_sdo_hold: assert property ((r_reg.st == smhp_pkg::SMHP_ST_XFER && !r_reg.cs_s && r_reg.rst_s &&
		!(r_reg.sck_d && !r_reg.sck_s)) |=> $stable(spi_sdo_o))
		else $error("output changed off a falling edge");
	a_cmd_accept: assert property (cmd_valid |-> $past(r_reg.cnt) == smhp_pkg::CMD_BITS &&
		$past(r_reg.cs_s) && cmd_word == $past(r_reg.sh_in))
		else $error("command taken from a bad frame");
	a_pd_follow: assert property (!r_reg.rst_s |=> power_down && !cmd_valid && !reference_on && !filter_on)
		else $error("reset pin did not power down");
	a_ref_follow: assert property (r_reg.rst_s |=> reference_on == $past(r_reg.pin_s[smhp_pkg::P_REF]))
		else $error("reference enable not followed");
	a_bpf_follow: assert property (r_reg.rst_s |=> filter_on == $past(r_reg.pin_s[smhp_pkg::P_BPF]))
		else $error("filter enable not followed");
	a_xtal_src: assert property (!r_reg.pin_s[smhp_pkg::P_XTAL_N] |=>
		clock_src == smhp_pkg::SMHP_SRC_XTAL)
		else $error("crystal not selected");
	a_cmos_src: assert property ((r_reg.pin_s[smhp_pkg::P_XTAL_N] && r_reg.pin_s[smhp_pkg::P_SEL1]) |=>
		clock_src == smhp_pkg::SMHP_SRC_CMOS)
		else $error("cmos source not selected");
	a_clkout_off: assert property ((clock_src == smhp_pkg::SMHP_SRC_CMOS) |=> !clock_out_pin)
		else $error("clock output echoes cmos clock");

	c_cmd_taken: cover property (cmd_valid && smhp_pkg::cmd_addr(cmd_word) == smhp_pkg::ADDR_CTRL);
	c_clkout_run: cover property (clock_out_pin ##1 !clock_out_pin);
	c_pd_exit: cover property (power_down ##1 !power_down);
endmodule

`default_nettype wire

// file: shared/smhp_pkg.sv
// smhp_pkg: constants, encodings and timing of the spi modem host port
// assumes a single 100 MHz system clock; every serial and strap pin is asynchronous
`default_nettype none

package smhp_pkg;
	// ------------------------------------------------------------
	// clock rates
	// ------------------------------------------------------------
	localparam int SYS_CLK_HZ = 100_000_000;
	localparam int SCLK_MAX_HZ = 12_500_000;
	localparam int SCLK_MIN_CYC = SYS_CLK_HZ / SCLK_MAX_HZ;

	// ------------------------------------------------------------
	// command word layout
	// ------------------------------------------------------------
	localparam int CMD_W = 24;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CMD_BITS = 5'h18;
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
	localparam int ADDR_HI = 23;
	localparam int ADDR_LO = 16;
	localparam logic [7:0] ADDR_CTRL = 8'h01;
	localparam logic [7:0] ADDR_MASK = 8'h02;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h03;

	// ------------------------------------------------------------
	// control fields, event mask, strap pin positions
	// ------------------------------------------------------------
	localparam int CTRL_W = 3;
	localparam int CTRL_IRQ_LEVEL = 0;
	localparam int CTRL_IRQ_POS = 1;
	localparam int CTRL_CLKOUT = 2;
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
	localparam int EVT_W = 8;
	localparam logic [EVT_W-1:0] MASK_RST = 8'h00;
	localparam int P_XTAL_N = 0;
	localparam int P_SEL0 = 1;
	localparam int P_SEL1 = 2;
	localparam int P_REF = 3;
	localparam int P_BPF = 4;
	localparam int PIN_W = 5;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int IRQ_PULSE_NS = 1000;
	localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int CLKOUT_HALF = 4;

	typedef enum logic [2:0] {SMHP_SRC_INT = 3'h1, SMHP_SRC_XTAL = 3'h2, SMHP_SRC_CMOS = 3'h4} smhp_clk_src_t;
	typedef enum logic [1:0] {SMHP_ST_IDLE = 2'h1, SMHP_ST_XFER = 2'h2} smhp_spi_st_t;

	// address field of a command word
	function automatic logic [7:0] cmd_addr(input logic [CMD_W-1:0] w);
		return w[ADDR_HI:ADDR_LO];
	endfunction
endpackage

`default_nettype wire

// file: core/smhp_irq_gen.sv
// smhp_irq_gen: sticky masked event latch and interrupt pin shaping
// assumes events, mask and mode come from logic on clk_sys; reset is synchronous
`default_nettype none

module smhp_irq_gen #(
	parameter int EVT_W = smhp_pkg::EVT_W,
	parameter int PULSE_CYC = smhp_pkg::IRQ_PULSE_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [EVT_W-1:0] event_in,
	input wire logic [EVT_W-1:0] mask,
	input wire logic level_mode,
	input wire logic active_high,
	input wire logic clear_pulse,
	input wire logic [EVT_W-1:0] clear_bits,
	output logic irq_pin,
	output logic [EVT_W-1:0] pending
);
	localparam int PW = $clog2(PULSE_CYC + 1);

	typedef struct packed {
		logic [EVT_W-1:0] pend;
		logic [PW-1:0] cnt;
		logic irq;
	} smhp_irq_state_t;

	smhp_irq_state_t r_reg, r_next;
	logic [EVT_W-1:0] hit;
	logic asserted;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// set beats clear so an event landing on its own clear is kept
	always_comb begin
		r_next = r_reg;
		hit = event_in & mask;
		r_next.pend = (r_reg.pend & ~(clear_pulse ? clear_bits : '0)) | hit;
		if (|(hit & ~r_reg.pend)) begin
			r_next.cnt = PW'(PULSE_CYC);
		end else if (r_reg.cnt != '0) begin
			r_next.cnt = r_reg.cnt - 1'b1;
		end
		asserted = level_mode ? |r_next.pend : (r_next.cnt != '0);
		r_next.irq = active_high ? asserted : ~asserted;
		if (sys_rst) begin
			r_next = '0;
			r_next.irq = ~active_high;
		end
	end

	always_ff @(posedge clk_sys) begin
		r_reg <= r_next;
	end

	assign irq_pin = r_reg.irq;
	assign pending = r_reg.pend;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_mask_gate: assert property ((r_reg.pend == '0 && (event_in & mask) == '0) |=> r_reg.pend == '0)
		else $error("masked event latched");
	a_level_out: assert property ((level_mode && active_high && |r_reg.pend && !clear_pulse) ##1
		(level_mode && active_high) |-> irq_pin)
		else $error("level interrupt not asserted");
	a_edge_width: assert property ((!level_mode && |(event_in & mask & ~r_reg.pend)) |=>
		r_reg.cnt == PW'(PULSE_CYC))
		else $error("edge pulse not started");
	c_edge_irq: cover property (!level_mode && r_reg.cnt == PW'(1));
endmodule

`default_nettype wire

// file: verification/smhp_spi_host.sv
// smhp_spi_host: behavioural host controller on the far side of the serial port
// assumes the bench calls its tasks one at a time; sclk idles high between frames
`default_nettype none

module smhp_spi_host (
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_sdi,
	input wire logic spi_sdo_o,
	input wire logic spi_sdo_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// link timing
	// ------------------------------------------------------------
	localparam realtime HALF = 62.5ns;
	logic sdo_last;

	// idle levels from time zero
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b1;
		spi_sdi = 1'b0;
		sdo_last = 1'b0;
	end

	// one frame of nbits, msb first; a floating sdo reads as the inverse of its last value
	task automatic xfer(input logic [23:0] w, input int nbits, output logic [23:0] rx);
		int i;
		rx = 24'h000000;
		spi_cs_n = 1'b0;
		// extra 2 ns keeps every sclk edge and the chip-select rise off the system clock edges; chip-select falls on the bench's negedge
		#(HALF + 2ns);
		for (i = 0; i < nbits; i++) begin
			spi_sdi = w[23-i];
			#(HALF);
			spi_sclk = 1'b0;
			sdo_last = spi_sdo_oe ? spi_sdo_o : ~sdo_last;
			rx = {rx[22:0], sdo_last};
			#(HALF);
			spi_sclk = 1'b1;
		end
		spi_sdi = ~spi_sdi; // released data line must not look stable
		spi_cs_n = 1'b1;
		#250ns;
	endtask

	// clock and data wiggle with chip-select high
	task automatic noise(input int n);
		repeat (n) begin
			spi_sdi = ~spi_sdi;
			spi_sclk = ~spi_sclk;
			#(HALF);
		end
		spi_sclk = 1'b1;
	endtask
endmodule

`default_nettype wire

// file: verification/tb.sv
// tb: self-checking bench of the serial modem host port
// assumes smhp_pkg and smhp_core are compiled first; the host model drives the serial pins
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, sys_rst, device_reset_n, spi_cs_n, spi_sclk, spi_sdi, spi_sdo_o, spi_sdo_oe;
	logic [23:0] tx_word, cmd_word, rx;
	logic cmd_valid, crystal_osc_enable_n, clock_scheme_sel0, clock_scheme_sel1, reference_enable;
	logic bandpass_filter_enable, crystal_osc_on, reference_on, filter_on, clock_out_pin, power_down, irq_pin;
	logic [7:0] event_in, irq_pending;
	smhp_pkg::smhp_clk_src_t clock_src;
	int miscompares, num_checks, cyc, nvalid;

	smhp_core DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .device_reset_n(device_reset_n),
		.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o),
		.spi_sdo_oe(spi_sdo_oe), .tx_word(tx_word), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
		.crystal_osc_enable_n(crystal_osc_enable_n), .clock_scheme_sel0(clock_scheme_sel0),
		.clock_scheme_sel1(clock_scheme_sel1), .reference_enable(reference_enable),
		.bandpass_filter_enable(bandpass_filter_enable), .clock_src(clock_src),
		.crystal_osc_on(crystal_osc_on), .reference_on(reference_on), .filter_on(filter_on),
		.clock_out_pin(clock_out_pin), .power_down(power_down), .event_in(event_in),
		.irq_pending(irq_pending), .irq_pin(irq_pin));

	smhp_spi_host host (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
		.spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe));

	// ------------------------------------------------------------
	// clock, pulse counter and hang guard
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// the run needs about 7k cycles; the ceiling leaves room without hiding a hang
	always @(posedge clk_sys) begin
		cyc++;
		if (cmd_valid === 1'b1) nvalid++;
		if (cyc == 40000) begin
			miscompares++;
			results();
		end
	end

	// ------------------------------------------------------------
	// compare and helper tasks
	// ------------------------------------------------------------
	task automatic chk_bit(input logic got, input logic exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask

	task automatic chk_vec(input logic [23:0] got, input logic [23:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// full command frame, then realign to the falling edge
	task automatic send(input logic [7:0] a, input logic [15:0] d);
		host.xfer({a, d}, 24, rx);
		wait_clk(2);
	endtask

	task automatic pulse_event(input logic [7:0] e);
		event_in = e;
		wait_clk(1);
		event_in = 8'h00;
	endtask

	task automatic results();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_frame();
		nvalid = 0;
		tx_word = 24'hA5C396;
		host.xfer(24'h7E1234, 24, rx);
		wait_clk(2);
		chk_vec(rx, 24'hA5C396, "sdo word");
		chk_vec(cmd_word, 24'h7E1234, "cmd word");
		chk_vec(24'(nvalid), 24'h000001, "one accept");
		chk_bit(spi_sdo_oe, 1'b0, "sdo released");
	endtask

	// short frame and cs-high activity are dropped; the next full frame still lines up
	task automatic t_refuse();
		nvalid = 0;
		host.xfer(24'h5A5A5A, 23, rx);
		host.noise(30);
		wait_clk(2);
		chk_vec(24'(nvalid), 24'h000000, "no accept");
		chk_vec(cmd_word, 24'h7E1234, "cmd kept");
		send(8'h7E, 16'h0F0F);
		chk_vec(cmd_word, 24'h7E0F0F, "count cleared");
		chk_vec(24'(nvalid), 24'h000001, "accept after");
	endtask

	task automatic t_straps();
		logic [4:0] s;
		smhp_pkg::smhp_clk_src_t e;
		for (int i = 0; i < 32; i++) begin
			s = 5'(i);
			{bandpass_filter_enable, reference_enable, clock_scheme_sel1, clock_scheme_sel0, crystal_osc_enable_n} = s;
			wait_clk(6);
			e = !s[0] ? smhp_pkg::SMHP_SRC_XTAL : (s[2] ? smhp_pkg::SMHP_SRC_CMOS : smhp_pkg::SMHP_SRC_INT);
			chk_vec(24'(clock_src), 24'(e), "clock source");
			chk_bit(crystal_osc_on, ~s[0], "crystal on");
			chk_bit(reference_on, s[3], "reference on");
			chk_bit(filter_on, s[4], "filter on");
		end
	endtask

	// count clock output changes over 80 cycles in four strap settings: internal, cmos, blocked, crystal
	task automatic t_clkout();
		int n;
		logic p;
		send(8'h01, 16'h0004);
		for (int k = 0; k < 4; k++) begin
			{clock_scheme_sel1, clock_scheme_sel0, crystal_osc_enable_n} = (k == 0) ? 3'h3 :
				((k == 1) ? 3'h7 : ((k == 2) ? 3'h1 : 3'h2));
			wait_clk(8);
			n = 0;
			p = clock_out_pin;
			repeat (80) begin
				wait_clk(1);
				if (clock_out_pin !== p) n++;
				p = clock_out_pin;
			end
			chk_vec(24'(n), (k == 0 || k == 3) ? 24'h000014 : 24'h000000, "clock out toggles");
		end
	endtask

	task automatic t_irq();
		logic idle;
		for (int m = 0; m < 4; m++) begin
			idle = ~m[1];
			send(8'h01, {14'h0000, m[1], m[0]});
			send(8'h02, 16'h0001);
			pulse_event(8'h02);
			wait_clk(4);
			chk_bit(irq_pin, idle, "masked event");
			chk_vec(24'(irq_pending), 24'h000000, "masked pending");
			pulse_event(8'h01);
			wait_clk(2);
			chk_bit(irq_pin, ~idle, "irq asserted");
			wait_clk(110);
			chk_bit(irq_pin, m[0] ? ~idle : idle, "level holds, edge ends");
			send(8'h03, 16'h0001);
			wait_clk(2);
			chk_vec(24'(irq_pending), 24'h000000, "cleared");
			chk_bit(irq_pin, idle, "irq idle");
		end
	endtask

	task automatic t_devrst();
		reference_enable = 1'b1;
		send(8'h01, 16'h0003);
		pulse_event(8'h01);
		wait_clk(3);
		device_reset_n = 1'b0;
		wait_clk(5);
		chk_bit(power_down, 1'b1, "power down");
		chk_vec(24'(irq_pending), 24'h000000, "pending cleared");
		chk_bit(reference_on, 1'b0, "reference off");
		device_reset_n = 1'b1;
		wait_clk(5);
		chk_bit(power_down, 1'b0, "resumed");
		chk_bit(irq_pin, 1'b1, "control cleared");
		chk_bit(reference_on, 1'b1, "reference back");
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{sys_rst, device_reset_n, crystal_osc_enable_n, clock_scheme_sel0} = 4'hF;
		{clock_scheme_sel1, reference_enable, bandpass_filter_enable} = 3'h0;
		tx_word = 24'h000000;
		event_in = 8'h00;
		wait_clk(10);
		chk_bit(power_down, 1'b1, "reset power down");
		chk_bit(spi_sdo_oe, 1'b0, "reset sdo float");
		chk_bit(irq_pin, 1'b1, "reset irq idle");
		sys_rst = 1'b0;
		wait_clk(5);
		chk_bit(power_down, 1'b0, "running");
		t_frame();
		t_refuse();
		t_straps();
		t_clkout();
		t_irq();
		t_devrst();
		results();
	end
endmodule

`default_nettype wire
